// [hw/asb_top.sv]
// Two-channel asynchronous serial data buffers: transmit holding and shift, receive shift and queue.
`default_nettype none

// ---------------------------------------------------------------------
// One channel
// ---------------------------------------------------------------------
module asb_channel (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic tx_wr_i,
   input wire logic [asb_pkg::DATA_W-1:0] tx_wdata_i,
   input wire logic rx_rd_i,
   input wire logic serial_in_pin_i,
   output logic serial_out_pin_o,
   output logic [asb_pkg::DATA_W-1:0] tx_holding_o,
   output logic tx_holding_empty_o,
   output logic tx_busy_o,
   output logic [asb_pkg::DATA_W-1:0] rx_fifo_head_o,
   output logic [asb_pkg::STAT_W-1:0] rx_status_o,
   output logic rx_full_flag_o
);
   import asb_pkg::*;

   // -----------------------------------------------------------------
   // Transmit state
   // -----------------------------------------------------------------
   asb_tx_state_t tx_state_ff, nxt_tx_state;
   logic [DATA_W-1:0] tx_hold_ff, nxt_tx_hold;
   logic tx_hold_vld_ff, nxt_tx_hold_vld;
   logic [FRAME_LEN-1:0] tx_shifter_ff, nxt_tx_shifter;
   logic [3:0] tx_bits_ff, nxt_tx_bits;
   logic [CNT_W-1:0] tx_div_ff, nxt_tx_div;
   logic tx_load;

   // -----------------------------------------------------------------
   // Receive state
   // -----------------------------------------------------------------
   asb_rx_state_t rx_state_ff, nxt_rx_state;
   logic [CNT_W-1:0] rx_cnt_ff, nxt_rx_cnt;
   logic [2:0] rx_bits_ff, nxt_rx_bits;
   logic [DATA_W-1:0] rx_shifter_ff, nxt_rx_shifter;
   logic [DATA_W-1:0] rx_held_ff, nxt_rx_held;
   logic rx_held_vld_ff, nxt_rx_held_vld;
   logic rx_held_fe_ff, nxt_rx_held_fe;
   logic rx_ovr_pend_ff, nxt_rx_ovr_pend;
   logic rx_done, rx_take;

   // -----------------------------------------------------------------
   // Queue wiring
   // -----------------------------------------------------------------
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [DATA_W+STAT_W-1:0] fifo_in_data;
   logic [DATA_W+STAT_W-1:0] fifo_out_data;

   // -----------------------------------------------------------------
   // Transmit next state
   // -----------------------------------------------------------------
   // The divider restarts on every load so the start bit is always a full bit time long.
   // A second write before the pending byte is loaded overwrites it; software is
   // expected to watch the holding-empty flag first.
   always_comb begin
      nxt_tx_state = tx_state_ff;
      nxt_tx_hold = tx_hold_ff;
      nxt_tx_shifter = tx_shifter_ff;
      nxt_tx_bits = tx_bits_ff;
      nxt_tx_div = tx_div_ff;
      tx_load = 1'b0;
      case (tx_state_ff)
         TX_IDLE: begin
            if (tx_hold_vld_ff) begin
               tx_load = 1'b1;
            end
         end
         TX_SHIFT: begin
            if (tx_div_ff == '0) begin
               nxt_tx_div = BIT_CNT;
               nxt_tx_shifter = {1'b1, tx_shifter_ff[FRAME_LEN-1:1]};
               nxt_tx_bits = tx_bits_ff - 1'b1;
               if (tx_bits_ff == 4'h1) begin
                  if (tx_hold_vld_ff) begin
                     tx_load = 1'b1;
                  end else begin
                     nxt_tx_state = TX_IDLE;
                  end
               end
            end else begin
               nxt_tx_div = tx_div_ff - 1'b1;
            end
         end
         default: begin
            nxt_tx_state = TX_IDLE;
            nxt_tx_shifter = '1;
         end
      endcase
      if (tx_load) begin
         nxt_tx_state = TX_SHIFT;
         nxt_tx_shifter = {1'b1, tx_hold_ff, 1'b0};
         nxt_tx_bits = 4'(FRAME_LEN);
         nxt_tx_div = BIT_CNT;
      end
      // A write in the cycle of a load still counts as a new pending byte.
      nxt_tx_hold_vld = (tx_hold_vld_ff & ~tx_load) | tx_wr_i;
      if (tx_wr_i) begin
         nxt_tx_hold = tx_wdata_i;
      end
   end

   // -----------------------------------------------------------------
   // Transmit registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tx_state_ff <= TX_IDLE;
         tx_hold_ff <= TX_HOLD_RST;
         tx_hold_vld_ff <= 1'b0;
         tx_shifter_ff <= '1;
         tx_bits_ff <= '0;
         tx_div_ff <= '0;
      end else begin
         tx_state_ff <= nxt_tx_state;
         tx_hold_ff <= nxt_tx_hold;
         tx_hold_vld_ff <= nxt_tx_hold_vld;
         tx_shifter_ff <= nxt_tx_shifter;
         tx_bits_ff <= nxt_tx_bits;
         tx_div_ff <= nxt_tx_div;
      end
   end

   // The holding register keeps its value after the load, so a read sees the last byte written.
   assign serial_out_pin_o = tx_shifter_ff[0];
   assign tx_holding_o = tx_hold_ff;
   assign tx_holding_empty_o = ~tx_hold_vld_ff;
   assign tx_busy_o = (tx_state_ff == TX_SHIFT);

   // -----------------------------------------------------------------
   // Receive next state
   // -----------------------------------------------------------------
   // The line is sampled once, in the middle of each bit; a start bit that is
   // gone at its middle is taken as a glitch and dropped.
   always_comb begin
      nxt_rx_state = rx_state_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_rx_bits = rx_bits_ff;
      nxt_rx_shifter = rx_shifter_ff;
      nxt_rx_held = rx_held_ff;
      nxt_rx_held_fe = rx_held_fe_ff;
      nxt_rx_held_vld = rx_held_vld_ff;
      nxt_rx_ovr_pend = rx_ovr_pend_ff;
      rx_done = 1'b0;
      rx_take = rx_held_vld_ff & fifo_in_ready;
      case (rx_state_ff)
         RX_IDLE: begin
            if (!serial_in_pin_i) begin
               nxt_rx_cnt = HALF_CNT;
               nxt_rx_state = RX_START;
            end
         end
         RX_START: begin
            if (rx_cnt_ff == '0) begin
               nxt_rx_cnt = BIT_CNT;
               nxt_rx_bits = '0;
               nxt_rx_state = serial_in_pin_i ? RX_IDLE : RX_DATA;
            end else begin
               nxt_rx_cnt = rx_cnt_ff - 1'b1;
            end
         end
         RX_DATA: begin
            if (rx_cnt_ff == '0) begin
               nxt_rx_cnt = BIT_CNT;
               nxt_rx_shifter = {serial_in_pin_i, rx_shifter_ff[DATA_W-1:1]};
               nxt_rx_bits = rx_bits_ff + 1'b1;
               if (rx_bits_ff == 3'h7) begin
                  nxt_rx_state = RX_STOP;
               end
            end else begin
               nxt_rx_cnt = rx_cnt_ff - 1'b1;
            end
         end
         RX_STOP: begin
            if (rx_cnt_ff == '0) begin
               rx_done = 1'b1;
               nxt_rx_state = RX_IDLE;
            end else begin
               nxt_rx_cnt = rx_cnt_ff - 1'b1;
            end
         end
         default: begin
            nxt_rx_state = RX_IDLE;
         end
      endcase
      if (rx_take) begin
         nxt_rx_held_vld = 1'b0;
         nxt_rx_ovr_pend = 1'b0;
      end
      // The shifter never waits for the queue; only the held character does.
      if (rx_done) begin
         if (rx_held_vld_ff && !rx_take) begin
            nxt_rx_ovr_pend = 1'b1;
         end else begin
            nxt_rx_held = rx_shifter_ff;
            nxt_rx_held_fe = ~serial_in_pin_i;
            nxt_rx_held_vld = 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Receive registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rx_state_ff <= RX_IDLE;
         rx_cnt_ff <= '0;
         rx_bits_ff <= '0;
         rx_shifter_ff <= '0;
         rx_held_ff <= '0;
         rx_held_fe_ff <= 1'b0;
         rx_held_vld_ff <= 1'b0;
         rx_ovr_pend_ff <= 1'b0;
      end else begin
         rx_state_ff <= nxt_rx_state;
         rx_cnt_ff <= nxt_rx_cnt;
         rx_bits_ff <= nxt_rx_bits;
         rx_shifter_ff <= nxt_rx_shifter;
         rx_held_ff <= nxt_rx_held;
         rx_held_fe_ff <= nxt_rx_held_fe;
         rx_held_vld_ff <= nxt_rx_held_vld;
         rx_ovr_pend_ff <= nxt_rx_ovr_pend;
      end
   end

   // -----------------------------------------------------------------
   // Receive queue
   // -----------------------------------------------------------------
   // Overrun rides on the last good character, so software sees it only once
   // that character is the oldest in the queue.
   assign fifo_in_data = {rx_ovr_pend_ff, rx_held_fe_ff, rx_held_ff};

   asb_fifo #(
      .WIDTH(DATA_W + STAT_W),
      .DEPTH(RX_DEPTH)
   ) u_rx_fifo (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(rx_held_vld_ff),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(rx_rd_i),
      .out_data_o(fifo_out_data)
   );

   // The head and its status read as zero while the queue is empty.
   assign rx_full_flag_o = fifo_out_valid;
   assign rx_fifo_head_o = fifo_out_valid ? fifo_out_data[DATA_W-1:0] : '0;
   assign rx_status_o = fifo_out_valid ? fifo_out_data[DATA_W+STAT_W-1:DATA_W] : '0;
endmodule

// ---------------------------------------------------------------------
// Top: I/O register decode over both channels
// ---------------------------------------------------------------------
module asb_top (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [asb_pkg::DATA_W-1:0] io_wdata_i,
   output logic [asb_pkg::DATA_W-1:0] io_rdata_o,
   input wire logic [asb_pkg::NUM_CH-1:0] serial_in_pin_i,
   output logic [asb_pkg::NUM_CH-1:0] serial_out_pin_o,
   output logic [asb_pkg::NUM_CH-1:0] rx_full_flag_o,
   output logic [asb_pkg::NUM_CH-1:0] rx_overrun_o,
   output logic [asb_pkg::NUM_CH-1:0] rx_frame_err_o,
   output logic [asb_pkg::NUM_CH-1:0] tx_holding_empty_o,
   output logic [asb_pkg::NUM_CH-1:0] tx_busy_o
);
   import asb_pkg::*;

   logic [DATA_W-1:0] tx_hold_w [NUM_CH];
   logic [DATA_W-1:0] rx_head_w [NUM_CH];
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;

   // -----------------------------------------------------------------
   // Channels
   // -----------------------------------------------------------------
   // Each channel is a full copy with only clock, reset and the write data bus in common, so traffic on
   // one can never hold up the other.
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [STAT_W-1:0] stat;

      asb_channel u_ch (
         .clk_sys_i(clk_sys_i),
         .sys_rst_i(sys_rst_i),
         .tx_wr_i(io_wr_i && io_addr_i == asb_ch_addr(ADDR_TX_CH0, ch)),
         .tx_wdata_i(io_wdata_i),
         .rx_rd_i(io_rd_i && io_addr_i == asb_ch_addr(ADDR_RX_CH0, ch)),
         .serial_in_pin_i(serial_in_pin_i[ch]),
         .serial_out_pin_o(serial_out_pin_o[ch]),
         .tx_holding_o(tx_hold_w[ch]),
         .tx_holding_empty_o(tx_holding_empty_o[ch]),
         .tx_busy_o(tx_busy_o[ch]),
         .rx_fifo_head_o(rx_head_w[ch]),
         .rx_status_o(stat),
         .rx_full_flag_o(rx_full_flag_o[ch])
      );

      assign rx_overrun_o[ch] = stat[STAT_OVR];
      assign rx_frame_err_o[ch] = stat[STAT_FE];
   end

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   // Read data is captured on the read strobe and held until the next read.
   // Only the four data registers decode; the shifters have no address.
   always_comb begin
      nxt_rdata = rdata_ff;
      if (io_rd_i) begin
         case (io_addr_i)
            ADDR_TX_CH0: nxt_rdata = tx_hold_w[0];
            ADDR_TX_CH1: nxt_rdata = tx_hold_w[1];
            ADDR_RX_CH0: nxt_rdata = rx_head_w[0];
            ADDR_RX_CH1: nxt_rdata = rx_head_w[1];
            default: nxt_rdata = RDATA_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rdata_ff <= RDATA_UNMAPPED;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign io_rdata_o = rdata_ff;
endmodule
`default_nettype wire

// [inc/asb_pkg.sv]
// Constants, types and helpers shared by the serial data-buffer block.
// Operation
// - Transmit shifter sends the byte taken from the holding register out the serial pin.
// - After each character, a waiting byte is loaded and sent with no software action.
// - With nothing to send, the serial output stays high without a break.
// - Holding registers decode at 06H and 07H and feed an empty shifter at once.
// - A holding register accepts a write while the shifter still sends a character.
// - Reading a holding register returns its contents and leaves transmission untouched.
// - Receive shifter builds characters from the bits on the serial input pin.
// - A finished character moves to the receive buffer whenever the buffer has room.
// - A character finishing while the held character still waits for the full buffer raises overrun.
// - Receive buffer is a four-deep queue read at 08H and 09H only.
// - Reading the receive data register returns the oldest buffered character.
// - The receive shifter keeps taking characters while the buffer is full.
// - No I/O address reaches either shifter.
// - Status bits ride with each character; software sees the oldest one's status.
// - Full flag sets on loading an empty buffer, even for an errored character.
`default_nettype none
package asb_pkg;
   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_TX_CH0 = 8'h06;
   localparam logic [7:0] ADDR_TX_CH1 = 8'h07;
   localparam logic [7:0] ADDR_RX_CH0 = 8'h08;
   localparam logic [7:0] ADDR_RX_CH1 = 8'h09;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
   localparam logic [7:0] TX_HOLD_RST = 8'h00;

   // -----------------------------------------------------------------
   // Widths and depths
   // -----------------------------------------------------------------
   localparam int NUM_CH = 2;
   localparam int DATA_W = 8;
   localparam int STAT_W = 2;
   localparam int STAT_OVR = 1;
   localparam int STAT_FE = 0;
   localparam int RX_DEPTH = 4;
   localparam int FRAME_LEN = 10;

   // -----------------------------------------------------------------
   // Bit timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int BIT_RATE_HZ = 9600;
   localparam int BIT_CYCLES = CLK_HZ / BIT_RATE_HZ;
   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] BIT_CNT = CNT_W'(BIT_CYCLES - 1);
   localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(BIT_CYCLES / 2 - 1);

   // -----------------------------------------------------------------
   // States
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SHIFT = 2'b10
   } asb_tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } asb_rx_state_t;

   // Address of a channel's register given the channel-0 address.
   function automatic logic [7:0] asb_ch_addr(input logic [7:0] base, input int ch);
      asb_ch_addr = base + 8'(ch);
   endfunction
endpackage
`default_nettype wire

// [hw/asb_fifo.sv]
// Parameterised first-in first-out queue with valid/ready on both sides.
`default_nettype none
module asb_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   import asb_pkg::*;

   // DEPTH must be a power of two so the pointers wrap on their own.
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] nxt_mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
   logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
   logic [CW-1:0] count_ff, nxt_count;
   logic push, pop;

   assign in_ready_o = (count_ff != CW'(DEPTH));
   assign out_valid_o = (count_ff != '0);
   assign out_data_o = mem_ff[rd_ptr_ff];

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      push = in_valid_i & in_ready_o;
      pop = out_valid_o & out_ready_i;
      nxt_mem = mem_ff;
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_count = count_ff;
      if (push) begin
         nxt_mem[wr_ptr_ff] = in_data_i;
         nxt_wr_ptr = wr_ptr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rd_ptr = rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_count = count_ff - 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
      end else begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
         mem_ff <= nxt_mem;
      end
   end
endmodule
`default_nettype wire

// [tb/asb_assertions.sv]
// Concurrent checks on the ports of the serial data-buffer top.
`default_nettype none
module asb_assertions (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] io_addr_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   input wire logic [asb_pkg::DATA_W-1:0] io_rdata_o,
   input wire logic [asb_pkg::NUM_CH-1:0] serial_out_pin_o,
   input wire logic [asb_pkg::NUM_CH-1:0] rx_full_flag_o,
   input wire logic [asb_pkg::NUM_CH-1:0] rx_overrun_o,
   input wire logic [asb_pkg::NUM_CH-1:0] rx_frame_err_o,
   input wire logic [asb_pkg::NUM_CH-1:0] tx_holding_empty_o,
   input wire logic [asb_pkg::NUM_CH-1:0] tx_busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import asb_pkg::*;
   default clocking dflt_cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   idle_line_high_a: assert property (
      (~tx_busy_o & ~serial_out_pin_o) == 2'h0) else $error("serial out low while idle");
   start_bit_low_a: assert property (
      $rose(tx_busy_o[0]) |-> !serial_out_pin_o[0]) else $error("frame began without start bit");
   no_gap_load_a: assert property (
      $fell(tx_busy_o[0]) |-> $past(tx_holding_empty_o[0])) else $error("shifter stopped with byte pending");
   write_pending_a: assert property (
      io_wr_i && io_addr_i == ADDR_TX_CH0 |=> !tx_holding_empty_o[0]) else $error("write not held");
   empty_load_a: assert property (
      io_wr_i && io_addr_i == ADDR_TX_CH0 && !tx_busy_o[0] && tx_holding_empty_o[0]
      |=> ##1 tx_busy_o[0] && tx_holding_empty_o[0]) else $error("idle shifter not loaded");
   unmapped_read_a: assert property (
      io_rd_i && !(io_addr_i inside {[8'h06:8'h09]}) |=> io_rdata_o == RDATA_UNMAPPED)
      else $error("unmapped read not zero");
   empty_read_a: assert property (
      io_rd_i && io_addr_i == ADDR_RX_CH1 && !rx_full_flag_o[1] |=> io_rdata_o == 8'h00)
      else $error("empty queue read not zero");
   rdata_stands_a: assert property (
      !io_rd_i |=> $stable(io_rdata_o)) else $error("read data moved without read");
   status_empty_a: assert property (
      (~rx_full_flag_o & (rx_overrun_o | rx_frame_err_o)) == 2'h0) else $error("status without char");
endmodule
bind asb_top asb_assertions asb_assertions_inst (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
   .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o), .serial_out_pin_o(serial_out_pin_o),
   .rx_full_flag_o(rx_full_flag_o), .rx_overrun_o(rx_overrun_o), .rx_frame_err_o(rx_frame_err_o),
   .tx_holding_empty_o(tx_holding_empty_o), .tx_busy_o(tx_busy_o)
);
`default_nettype wire

// [tb/asb_serial_partner.sv]
// Remote serial device: sends 8N1 frames and decodes channel 0 output.
`default_nettype none
module asb_serial_partner (
   input wire logic clk_sys_i,
   input wire logic [asb_pkg::NUM_CH-1:0] serial_out_pin_i,
   output logic [asb_pkg::NUM_CH-1:0] serial_in_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import asb_pkg::*;
   logic [DATA_W-1:0] got_q[$];
   initial serial_in_pin_o = 2'h3;
   task automatic bit_time();
      repeat (BIT_CYCLES) @(posedge clk_sys_i);
   endtask
   // A low stop bit is followed by one idle bit so the next start edge exists.
   task automatic send(input int ch, input logic [7:0] val, input logic stop);
      @(posedge clk_sys_i);
      serial_in_pin_o[ch] <= 1'b0;
      bit_time();
      for (int i = 0; i < 8; i++) begin
         serial_in_pin_o[ch] <= val[i];
         bit_time();
      end
      serial_in_pin_o[ch] <= stop;
      bit_time();
      serial_in_pin_o[ch] <= 1'b1;
      if (!stop) bit_time();
   endtask
   // A bad stop bit turns the byte unknown so any compare on it fails.
   initial begin
      logic [7:0] v;
      forever begin
         @(posedge clk_sys_i);
         if (serial_out_pin_i[0] === 1'b0) begin
            repeat (BIT_CYCLES / 2) @(posedge clk_sys_i);
            for (int i = 0; i < 8; i++) begin
               bit_time();
               v[i] = serial_out_pin_i[0];
            end
            bit_time();
            if (serial_out_pin_i[0] !== 1'b1) v = 8'hxx;
            got_q.push_back(v);
         end
      end
   end
endmodule
`default_nettype wire

// [tb/test_async_serial_data_buffers.sv]
// Self-checking bench for the two-channel serial data buffers.
`default_nettype none
module test_async_serial_data_buffers;
   timeunit 1ns;
   timeprecision 1ns;
   import asb_pkg::*;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] io_addr_i = 8'h00;
   logic io_wr_i = 1'b0;
   logic io_rd_i = 1'b0;
   logic [7:0] io_wdata_i = 8'h00;
   logic [7:0] io_rdata_o;
   logic [1:0] serial_in_pin_i, serial_out_pin_o, rx_full_flag_o, rx_overrun_o;
   logic [1:0] rx_frame_err_o, tx_holding_empty_o, tx_busy_o;
   int failures = 0;
   int checks = 0;
   asb_top asb_top_inst (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
      .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
      .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
      .rx_full_flag_o(rx_full_flag_o), .rx_overrun_o(rx_overrun_o), .rx_frame_err_o(rx_frame_err_o),
      .tx_holding_empty_o(tx_holding_empty_o), .tx_busy_o(tx_busy_o)
   );
   asb_serial_partner asb_serial_partner_inst (
      .clk_sys_i(clk_sys_i), .serial_out_pin_i(serial_out_pin_o), .serial_in_pin_o(serial_in_pin_i)
   );
   always #50 clk_sys_i = ~clk_sys_i;
   task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_bit(input string name, input logic exp, input logic got);
      check_val(name, {7'h00, exp}, {7'h00, got});
   endtask
   // Bus tasks start on a rising edge and return at a falling edge, where outputs are settled.
   task automatic io_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      io_addr_i <= a;
      io_wdata_i <= d;
      io_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      io_wr_i <= 1'b0;
      @(negedge clk_sys_i);
   endtask
   task automatic io_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      io_addr_i <= a;
      io_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      io_rd_i <= 1'b0;
      @(negedge clk_sys_i);
      d = io_rdata_o;
   endtask
   task automatic print_verdict();
      $display("Counts: %0d checks, %0d failures", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic test_regs();
      logic [7:0] d;
      check_val("idle lines", 8'h03, {6'h00, serial_out_pin_o});
      io_read(8'h0a, d);
      check_val("unmapped read", RDATA_UNMAPPED, d);
      io_write(ADDR_RX_CH0, 8'h55);
      io_read(ADDR_RX_CH0, d);
      check_val("rx ch0 after write", 8'h00, d);
      check_val("rx full flags", 8'h00, {6'h00, rx_full_flag_o});
      $display("test_regs done");
   endtask
   task automatic test_tx();
      logic [7:0] d;
      io_write(ADDR_TX_CH1, 8'h96);
      io_write(ADDR_TX_CH0, 8'ha5);
      io_write(ADDR_TX_CH0, 8'h3c);
      check_bit("tx pending", 1'b0, tx_holding_empty_o[0]);
      io_read(ADDR_TX_CH0, d);
      check_val("tx holding read", 8'h3c, d);
      check_bit("tx busy after read", 1'b1, tx_busy_o[0]);
      io_read(ADDR_TX_CH1, d);
      check_val("tx ch1 holding read", 8'h96, d);
      check_bit("tx ch1 busy", 1'b1, tx_busy_o[1]);
      for (int i = 0; i < 25000 && asb_serial_partner_inst.got_q.size() < 2; i++)
         @(negedge clk_sys_i);
      check_val("tx first byte", 8'ha5, asb_serial_partner_inst.got_q[0]);
      check_val("tx second byte", 8'h3c, asb_serial_partner_inst.got_q[1]);
      repeat (BIT_CYCLES) @(negedge clk_sys_i);
      check_bit("tx busy at end", 1'b0, tx_busy_o[0]);
      check_bit("ch1 line quiet", 1'b1, serial_out_pin_o[1]);
      $display("test_tx done");
   endtask
   // Six frames: four fill the queue, one waits as the held character, the last overruns.
   task automatic test_rx();
      logic [7:0] exp_d[5] = '{8'h81, 8'h42, 8'h24, 8'h18, 8'he7};
      logic [7:0] d;
      for (int i = 0; i < 5; i++)
         asb_serial_partner_inst.send(1, exp_d[i], i != 0);
      asb_serial_partner_inst.send(1, 8'h5a, 1'b1);
      @(negedge clk_sys_i);
      check_bit("rx full ch1", 1'b1, rx_full_flag_o[1]);
      check_bit("rx full ch0", 1'b0, rx_full_flag_o[0]);
      for (int i = 0; i < 5; i++) begin
         check_bit("rx frame err", i == 0, rx_frame_err_o[1]);
         check_bit("rx overrun", i == 4, rx_overrun_o[1]);
         io_read(ADDR_RX_CH1, d);
         check_val("rx data", exp_d[i], d);
      end
      io_read(ADDR_RX_CH1, d);
      check_val("rx empty read", 8'h00, d);
      check_bit("rx full cleared", 1'b0, rx_full_flag_o[1]);
      $display("test_rx done");
   endtask
   initial begin
      repeat (95000) @(posedge clk_sys_i);
      failures++;
      $display("Error watchdog expected done seen hang");
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      @(negedge clk_sys_i);
      test_regs();
      test_tx();
      test_rx();
      print_verdict();
   end
endmodule
`default_nettype wire
